/* File: logic/asdc_pkg.sv */
// package for the converter start-wait and correction block
// assumes one 100 MHz clock and a converter clock enable made from it
package asdc_pkg;

	// word widths and scaling
	localparam int DATA_W = 24;
	localparam int GAIN_SHIFT = 22;
	localparam logic [23:0] OFS_RESET = 24'h000000;
	localparam logic [23:0] GAIN_UNITY = 24'h400000;

	// register map, byte registers
	localparam logic [3:0] ADDR_OFS_LO = 4'h0;
	localparam logic [3:0] ADDR_OFS_MID = 4'h1;
	localparam logic [3:0] ADDR_OFS_HI = 4'h2;
	localparam logic [3:0] ADDR_GAIN_LO = 4'h3;
	localparam logic [3:0] ADDR_GAIN_MID = 4'h4;
	localparam logic [3:0] ADDR_GAIN_HI = 4'h5;
	localparam logic [3:0] ADDR_CTRL = 4'h6;
	localparam logic [3:0] ADDR_STATUS = 4'h7;
	localparam logic [3:0] ADDR_RES_LO = 4'h8;
	localparam logic [3:0] ADDR_RES_MID = 4'h9;
	localparam logic [3:0] ADDR_RES_HI = 4'hA;
	localparam logic [7:0] CTRL_RESET = 8'h00;

	// status bit positions
	localparam int STAT_RDY_N = 0;
	localparam int STAT_SETTLED = 1;
	localparam int STAT_WAITING = 2;
	localparam int STAT_CONV = 3;

	// start wait: code 1 is 64 converter clocks, doubling per code
	localparam logic [12:0] WAIT_BASE_TICKS = 13'h0040;

	// converter clock divider default (100 MHz / 14, near 7.14 MHz)
	localparam int CONV_DIV_DEFAULT = 14;

	// rate codes with special continuous settling
	localparam logic [2:0] RATE_3600 = 3'h6;
	localparam logic [2:0] RATE_14400 = 3'h7;

	// continuous settling in result periods, first / second order
	localparam logic [2:0] CONT_SINC1 = 3'h2;
	localparam logic [2:0] CONT_SINC2 = 3'h3;
	localparam logic [2:0] CONT_3600_SINC1 = 3'h3;
	localparam logic [2:0] CONT_3600_SINC2 = 3'h4;
	localparam logic [2:0] CONT_14400_SINC1 = 3'h6;
	localparam logic [2:0] CONT_14400_SINC2 = 3'h7;

	// settling after start at 10 SPS, zero wait, in microseconds
	localparam int SETTLE_10_SINC1_US = 100000;
	localparam int SETTLE_10_SINC2_US = 200000;
	// fastest rate, in nanoseconds (filter latency, not whole periods)
	localparam int SETTLE_FAST_SINC1_NS = 424000;
	localparam int SETTLE_FAST_SINC2_NS = 563000;
	// results to drop after a filter clear for second order
	localparam logic [1:0] FIRST_DROP_SINC2 = 2'(SETTLE_10_SINC2_US / SETTLE_10_SINC1_US - 1);

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WAIT = 2'b01,
		ST_CONV = 2'b10,
		ST_DRAIN = 2'b11
	} asdc_state_t;

	typedef struct packed {
		logic pulse;
		logic [2:0] rate;
		logic order;
		logic [2:0] wait_code;
	} asdc_ctrl_t;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} asdc_bus_t;

	typedef struct packed {
		logic valid;
		logic [23:0] data;
	} asdc_filt_t;

	typedef struct packed {
		logic load_offset;
		logic load_gain;
		logic [23:0] word;
	} asdc_cal_t;

endpackage

/* File: logic/asdc_correct.sv */
// offset subtract, gain scale, saturate; purely combinational
// assumes the caller registers the result
`timescale 1ns/1ps

module asdc_correct #(
	parameter int W = 24,
	parameter int SHIFT = 22
) (
	input wire logic [W-1:0] raw,
	input wire logic [W-1:0] ofs,
	input wire logic [W-1:0] gain,
	output logic [W-1:0] corrected
);
	localparam logic signed [2*W+1:0] POS_MAX = {{(W+3){1'b0}}, {(W-1){1'b1}}};
	localparam logic signed [2*W+1:0] NEG_MIN = {{(W+3){1'b1}}, {(W-1){1'b0}}};

	logic signed [W:0] diff;
	logic signed [2*W+1:0] prod;
	logic signed [2*W+1:0] scaled;

	// one extra bit keeps the difference exact over the full offset range
	assign diff = $signed({raw[W-1], raw}) - $signed({ofs[W-1], ofs});
	assign prod = diff * $signed({1'b0, gain});
	// arithmetic shift floors toward minus infinity
	assign scaled = prod >>> SHIFT;

	// clip instead of wrapping
	always_comb begin
		if (scaled > POS_MAX) begin
			corrected = POS_MAX[W-1:0];
		end else if (scaled < NEG_MIN) begin
			corrected = NEG_MIN[W-1:0];
		end else begin
			corrected = scaled[W-1:0];
		end
	end
endmodule

/* File: logic/asdc_top.sv */
// start sequencing, settling hold-off and result correction of the converter
// assumes filter results and command pulses arrive on ref_clk; start_pin is asynchronous
`timescale 1ns/1ps

// How it works
// - a start from pin or command holds off the filter for the wait
// - wait code 0 means none, code 1 is 64 clocks, doubling to 4096
// - when the wait ends the filter is cleared and conversion begins
// - ready flag (low) drops with each result; first result is settled
// - first result comes after the wait plus the filter settling
// - settling after start is one period first order, two second order
// - the result after an input step is treated as unsettled
// - continuous settled flag needs 2/3, 3/4 or 6/7 results by rate
// - result is filter output minus offset, times gain over 400000h
// - offset and gain words load by register write or calibration
// - offset word is 24-bit two's complement
// - offset resets to zero and zero leaves the result unchanged
// - gain word is 24-bit unsigned, 400000h is unity
// - gain 800000h doubles, 200000h halves, zero gives zero
// - gain resets to unity
// - offset bytes: low 7..0, mid 15..8, high 23..16
// - gain bytes in the same order
// - ready flag goes high at once on a start request
// - start and stop commands act in the cycle their pulse arrives
module asdc_top
	import asdc_pkg::*;
#(
	parameter int CONV_DIV = CONV_DIV_DEFAULT
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic start_pin,
	input wire logic cmd_start,
	input wire logic cmd_stop,
	input wire logic input_step,
	input wire asdc_bus_t bus,
	input wire asdc_filt_t filt,
	input wire asdc_cal_t cal,
	output logic [7:0] rd_data,
	output logic result_available_n,
	output logic result_valid,
	output logic [23:0] result_data,
	output logic data_settled,
	output logic filter_clear
);
	typedef struct packed {
		asdc_state_t state;
		logic [12:0] wait_cnt;
		logic [1:0] drop;
		logic [2:0] steady;
		logic settled;
		logic [23:0] ofs;
		logic [23:0] gain;
		asdc_ctrl_t ctrl;
		logic [23:0] result;
		logic rdy_n;
		logic res_valid;
		logic filt_clr;
		logic [7:0] rd_data;
		logic pin_s1;
		logic pin_s2;
		logic pin_prev;
		logic [7:0] div_cnt;
	} asdc_regs_t;

	asdc_regs_t st;
	asdc_regs_t next_st;
	logic [23:0] corrected;
	logic tick;
	logic start_req;
	logic stop_req;
	logic accept;

	// wait length in converter clocks for a code
	function automatic logic [12:0] wait_ticks(input logic [2:0] code);
		wait_ticks = WAIT_BASE_TICKS << (code - 3'h1);
	endfunction

	// results needed for settled data while converting continuously
	function automatic logic [2:0] cont_need(input logic [2:0] rate, input logic order);
		if (rate == RATE_14400) begin
			cont_need = order ? CONT_14400_SINC2 : CONT_14400_SINC1;
		end else if (rate == RATE_3600) begin
			cont_need = order ? CONT_3600_SINC2 : CONT_3600_SINC1;
		end else begin
			cont_need = order ? CONT_SINC2 : CONT_SINC1;
		end
	endfunction

	asdc_correct #(
		.W(DATA_W),
		.SHIFT(GAIN_SHIFT)
	) u_correct (
		.raw(filt.data),
		.ofs(st.ofs),
		.gain(st.gain),
		.corrected(corrected)
	);

	// start and stop sources; pin edges use the second synchroniser stage
	assign tick = (st.div_cnt == 8'h00);
	assign start_req = (st.pin_s2 & ~st.pin_prev) | cmd_start;
	assign stop_req = (~st.pin_s2 & st.pin_prev) | cmd_stop;
	// a result that meets the clear pulse predates the clear and is stale
	assign accept = filt.valid && !start_req && !st.filt_clr && st.drop == 2'h0
		&& (st.state == ST_CONV || st.state == ST_DRAIN);

	always_comb begin
		next_st = st;
		next_st.res_valid = 1'b0;
		next_st.filt_clr = 1'b0;
		next_st.rd_data = 8'h00;
		next_st.pin_s1 = start_pin;
		next_st.pin_s2 = st.pin_s1;
		next_st.pin_prev = st.pin_s2;
		next_st.div_cnt = tick ? 8'(CONV_DIV - 1) : st.div_cnt - 8'h01;

		// register writes; bytes land low, mid, high
		if (bus.wr) begin
			case (bus.addr)
				ADDR_OFS_LO: next_st.ofs[7:0] = bus.wdata;
				ADDR_OFS_MID: next_st.ofs[15:8] = bus.wdata;
				ADDR_OFS_HI: next_st.ofs[23:16] = bus.wdata;
				ADDR_GAIN_LO: next_st.gain[7:0] = bus.wdata;
				ADDR_GAIN_MID: next_st.gain[15:8] = bus.wdata;
				ADDR_GAIN_HI: next_st.gain[23:16] = bus.wdata;
				ADDR_CTRL: next_st.ctrl = bus.wdata;
				default: ;
			endcase
		end
		// calibration outranks a register write in the same cycle
		if (cal.load_offset) begin
			next_st.ofs = cal.word;
		end
		if (cal.load_gain) begin
			next_st.gain = cal.word;
		end

		// reads answer next cycle; unmapped addresses read zero
		if (bus.rd) begin
			case (bus.addr)
				ADDR_OFS_LO: next_st.rd_data = st.ofs[7:0];
				ADDR_OFS_MID: next_st.rd_data = st.ofs[15:8];
				ADDR_OFS_HI: next_st.rd_data = st.ofs[23:16];
				ADDR_GAIN_LO: next_st.rd_data = st.gain[7:0];
				ADDR_GAIN_MID: next_st.rd_data = st.gain[15:8];
				ADDR_GAIN_HI: next_st.rd_data = st.gain[23:16];
				ADDR_CTRL: next_st.rd_data = st.ctrl;
				ADDR_STATUS: begin
					next_st.rd_data[STAT_RDY_N] = st.rdy_n;
					next_st.rd_data[STAT_SETTLED] = st.settled;
					next_st.rd_data[STAT_WAITING] = (st.state == ST_WAIT);
					next_st.rd_data[STAT_CONV] = st.state[1];
				end
				ADDR_RES_LO: next_st.rd_data = st.result[7:0];
				ADDR_RES_MID: next_st.rd_data = st.result[15:8];
				ADDR_RES_HI: begin
					next_st.rd_data = st.result[23:16];
					// reading the top byte retires the data in gate mode
					if (!st.ctrl.pulse) begin
						next_st.rdy_n = 1'b1;
					end
				end
				default: next_st.rd_data = 8'h00;
			endcase
		end

		// sequencing; a start restarts from any state
		if (start_req) begin
			next_st.rdy_n = 1'b1;
			next_st.steady = 3'h0;
			if (st.ctrl.wait_code == 3'h0) begin
				next_st.filt_clr = 1'b1;
				next_st.drop = st.ctrl.order ? FIRST_DROP_SINC2 : 2'h0;
				next_st.state = ST_CONV;
			end else begin
				next_st.wait_cnt = wait_ticks(st.ctrl.wait_code);
				next_st.state = ST_WAIT;
			end
		end else begin
			case (st.state)
				ST_IDLE: ;
				ST_WAIT: begin
					if (stop_req) begin
						next_st.state = ST_IDLE;
					end else if (tick) begin
						if (st.wait_cnt == 13'h0001) begin
							// wait spent: clear the filter, hold off unsettled outputs
							next_st.filt_clr = 1'b1;
							next_st.drop = st.ctrl.order ? FIRST_DROP_SINC2 : 2'h0;
							next_st.state = ST_CONV;
						end else begin
							next_st.wait_cnt = st.wait_cnt - 13'h0001;
						end
					end
				end
				ST_CONV, ST_DRAIN: begin
					// a stop lets the conversion in flight finish
					if (stop_req && st.state == ST_CONV) begin
						next_st.state = ST_DRAIN;
					end
					if (filt.valid && !st.filt_clr && st.drop != 2'h0) begin
						next_st.drop = st.drop - 2'h1;
					end else if (accept) begin
						next_st.result = corrected;
						next_st.rdy_n = 1'b0;
						next_st.res_valid = 1'b1;
						if (st.steady != 3'h7) begin
							next_st.steady = st.steady + 3'h1;
						end
						if (st.state == ST_DRAIN || stop_req || st.ctrl.pulse) begin
							next_st.state = ST_IDLE;
						end
					end
				end
				default: next_st.state = ST_IDLE;
			endcase
		end

		// an input step spoils the blend of recent results
		if (input_step) begin
			next_st.steady = 3'h0;
		end
		next_st.settled = (next_st.steady >= cont_need(next_st.ctrl.rate, next_st.ctrl.order));
	end

	// the whole block state; reset gives zero offset and unity gain
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			st <= '0;
			st.state <= ST_IDLE;
			st.ofs <= OFS_RESET;
			st.gain <= GAIN_UNITY;
			st.ctrl <= CTRL_RESET;
			st.rdy_n <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	// outputs straight from the state flops
	assign rd_data = st.rd_data;
	assign result_available_n = st.rdy_n;
	assign result_valid = st.res_valid;
	assign result_data = st.result;
	assign data_settled = st.settled;
	assign filter_clear = st.filt_clr;

	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);

	a_start_flag_high: assert property (start_req |=> result_available_n && !result_valid)
		else $error("ready flag not high after start");

	a_zero_wait_clear: assert property ((start_req && st.ctrl.wait_code == 3'h0) |=> filter_clear)
		else $error("zero wait did not clear filter at once");

	a_wait_expiry: assert property ((st.state == ST_WAIT && st.wait_cnt == 13'h0001 && tick
		&& !start_req && !stop_req) |=> filter_clear && st.state == ST_CONV)
		else $error("filter not cleared when wait ended");

	a_wait_load: assert property ((start_req && st.ctrl.wait_code == 3'h7)
		|=> st.state == ST_WAIT && st.wait_cnt == 13'h1000)
		else $error("longest wait not loaded as 4096");

	a_no_early_clear: assert property ((st.state == ST_WAIT && st.wait_cnt > 13'h0001 && !start_req)
		|=> !filter_clear)
		else $error("filter cleared before wait ended");

	a_drop_unsettled: assert property ((st.state == ST_CONV && st.drop != 2'h0 && filt.valid && !start_req)
		|=> !result_valid && $stable(result_data))
		else $error("unsettled first result delivered");

	a_result_flag_low: assert property (result_valid |-> !result_available_n)
		else $error("result given with ready flag high");

	a_identity_pass: assert property ((accept && st.ofs == 24'h000000 && st.gain == GAIN_UNITY)
		|=> result_valid ##0 result_data == $past(filt.data))
		else $error("zero offset and unity gain changed data");

	a_gain_zero: assert property ((accept && st.gain == 24'h000000) |=> result_data == 24'h000000)
		else $error("zero gain did not give zero");

	a_offset_clip: assert property ((accept && st.gain == GAIN_UNITY && st.ofs == 24'h800000
		&& filt.data == 24'h7FFFFF) |=> result_data == 24'h7FFFFF)
		else $error("positive overflow not clipped");

	a_cal_load: assert property (cal.load_offset |=> st.ofs == $past(cal.word))
		else $error("calibration offset not loaded");

	a_gain_byte_hi: assert property ((bus.wr && bus.addr == ADDR_GAIN_HI && !cal.load_gain)
		|=> st.gain[23:16] == $past(bus.wdata))
		else $error("gain high byte not written");

	a_offset_byte_lo: assert property ((bus.wr && bus.addr == ADDR_OFS_LO && !cal.load_offset)
		|=> st.ofs[7:0] == $past(bus.wdata))
		else $error("offset low byte not written");

	// sequencing, settling, calibration and clipping checks beside the state update
	a_stale_ignored: assert property ((filt.valid && st.filt_clr)
		|=> !result_valid && $stable(result_data))
		else $error("result from before the filter clear delivered");

	a_clear_single: assert property ((filter_clear && !start_req)
		|=> !filter_clear)
		else $error("filter clear longer than one cycle");

	a_start_waits: assert property ((start_req && st.ctrl.wait_code != 3'h0)
		|=> st.state == ST_WAIT && !filter_clear)
		else $error("nonzero wait did not hold off the filter");

	a_wait_count_down: assert property ((st.state == ST_WAIT && tick && st.wait_cnt > 13'h0001
		&& !start_req && !stop_req) |=> st.state == ST_WAIT && st.wait_cnt == $past(st.wait_cnt) - 13'h0001)
		else $error("wait counter did not step once per tick");

	a_flag_low_hold: assert property ((!result_available_n && !start_req
		&& !(bus.rd && bus.addr == ADDR_RES_HI)) |=> !result_available_n)
		else $error("ready flag rose without start or read");

	a_step_unsettle: assert property (input_step
		|=> !data_settled)
		else $error("input step left data marked settled");

	a_settled_count: assert property ((accept && !input_step && !bus.wr && st.steady == 3'h1
		&& st.ctrl.rate < RATE_3600 && !st.ctrl.order) |=> data_settled)
		else $error("settled flag late after second result");

	a_cal_gain: assert property (cal.load_gain
		|=> st.gain == $past(cal.word))
		else $error("calibration gain not loaded");

	a_neg_clip: assert property ((accept && st.gain == 24'h800000 && st.ofs == 24'h000001
		&& filt.data == 24'h800000) |=> result_data == 24'h800000)
		else $error("negative overflow not clipped");

	a_drain_ends: assert property ((st.state == ST_DRAIN && accept)
		|=> st.state == ST_IDLE)
		else $error("stopped conversion did not end after its result");
endmodule

/* File: testbench/asdc_filter_model.sv */
// stand-in for the digital filter that feeds the block its raw results
// assumes the block's clock; each result carries sample plus its index since the last clear
`timescale 1ns/1ps
module asdc_filter_model
	import asdc_pkg::*;
#(
	parameter int PERIOD = 20
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic filter_clear,
	input wire logic [23:0] sample,
	output asdc_filt_t filt
);
	int cnt;
	logic [23:0] idx;

	// filter runs on its own from the first clear on; the index lets the bench see which result got through
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cnt <= 0;
			idx <= '0;
			filt <= '0;
		end else begin
			filt.valid <= 1'b0;
			filt.data <= ~filt.data; // stale data lines keep moving so nothing passes by luck
			if (filter_clear) begin
				cnt <= 1; // a clear restarts the filter cycle
				idx <= '0;
			end else if (cnt == PERIOD) begin
				cnt <= 1;
				idx <= idx + 24'h000001;
				filt.valid <= 1'b1;
				filt.data <= sample + idx;
			end else if (cnt != 0) begin
				cnt <= cnt + 1;
			end
		end
	end
endmodule

/* File: testbench/adc_start_delay_and_correction_test.sv */
// self-checking bench for the start wait and correction block
// assumes the filter stand-in on the raw side; registers reached over the byte port
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
	$display("[FAIL] t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module adc_start_delay_and_correction_test;
	import asdc_pkg::*;
	localparam int DIV = 2;
	localparam int LIMIT = 60000;
	logic ref_clk, rst, start_pin, cmd_start, cmd_stop, input_step, rd_seen;
	asdc_bus_t bus;
	asdc_filt_t filt;
	asdc_cal_t cal;
	logic [23:0] sample, result_data, exp_r, w;
	logic [7:0] rd_data, exp_b;
	logic result_available_n, result_valid, data_settled, filter_clear;
	int mismatches, num_checks, cycles, seed_v;
	logic [7:0] rdq[$];
	logic [23:0] resq[$];

	asdc_top #(.CONV_DIV(DIV)) asdc_top_i (.ref_clk(ref_clk), .rst(rst), .start_pin(start_pin),
		.cmd_start(cmd_start), .cmd_stop(cmd_stop), .input_step(input_step), .bus(bus), .filt(filt),
		.cal(cal), .rd_data(rd_data), .result_available_n(result_available_n), .result_valid(result_valid),
		.result_data(result_data), .data_settled(data_settled), .filter_clear(filter_clear));
	asdc_filter_model asdc_filter_model_i (.ref_clk(ref_clk), .rst(rst), .filter_clear(filter_clear),
		.sample(sample), .filt(filt));

	// clock generator
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	// reference correction: floor after the shift, clip rather than wrap
	function automatic logic [23:0] corr(input logic [23:0] r, input logic [23:0] o, input logic [23:0] g);
		logic signed [49:0] p;
		p = ($signed({r[23], r}) - $signed({o[23], o})) * $signed({1'b0, g});
		p = p >>> 22;
		if (p > 50'sd8388607) return 24'h7FFFFF;
		if (p < -50'sd8388608) return 24'h800000;
		return p[23:0];
	endfunction

	task stop_test;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// hang guard, sized well above the longest wait code run
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			mismatches++;
			stop_test();
		end
	end

	// watcher: read data one cycle after the strobe, results whenever they appear
	always @(negedge ref_clk) begin
		if (rd_seen) begin
			exp_b = rdq.size() ? rdq.pop_front() : 8'hXX;
			`CHK(rd_data, exp_b)
		end
		if (result_valid === 1'b1) begin
			exp_r = resq.size() ? resq.pop_front() : 24'hXXXXXX;
			`CHK(result_data, exp_r)
		end
		rd_seen = bus.rd;
	end

	// bus tasks leave one idle cycle so a strobe is never set twice in a step
	task wr(input logic [3:0] a, input logic [7:0] d);
		bus.addr <= a;
		bus.wdata <= d;
		bus.wr <= 1'b1;
		@(posedge ref_clk);
		bus.wr <= 1'b0;
		@(posedge ref_clk);
	endtask

	task rd(input logic [3:0] a, input logic [7:0] e);
		rdq.push_back(e);
		bus.addr <= a;
		bus.rd <= 1'b1;
		@(posedge ref_clk);
		bus.rd <= 1'b0;
		@(posedge ref_clk);
	endtask

	task setup(input logic [7:0] ctrl, input logic [23:0] o, input logic [23:0] g);
		for (int j = 0; j < 3; j++) begin
			wr(4'(j), o[8*j +: 8]);
			wr(4'(j + 3), g[8*j +: 8]);
		end
		wr(ADDR_CTRL, ctrl);
	endtask

	task wait_res;
		int i;
		i = 0;
		@(negedge ref_clk);
		while (result_valid !== 1'b1 && i < 20000) begin
			@(negedge ref_clk);
			i++;
		end
		if (result_valid !== 1'b1) mismatches++; // no result within the limit
	endtask

	// one start, one result; second order must skip the unsettled first result
	task conv(input logic [7:0] ctrl, input logic [23:0] o, input logic [23:0] g, input logic [23:0] r,
		input logic pin);
		int n;
		int nt;
		setup(ctrl, o, g);
		sample <= r;
		resq.push_back(corr(r + 24'(ctrl[3]), o, g));
		if (pin) start_pin <= 1'b1;
		else cmd_start <= 1'b1;
		@(posedge ref_clk);
		cmd_start <= 1'b0;
		@(negedge ref_clk);
		if (!pin) begin
			`CHK(result_available_n, 1'b1)
			nt = (ctrl[2:0] == 3'h0) ? 0 : 64 << (ctrl[2:0] - 1);
			n = 0;
			while (filter_clear !== 1'b1 && n < 10000) begin
				@(negedge ref_clk);
				n++;
			end
			`CHK((nt == 0) ? (n == 0) : (n >= nt * DIV - 2 && n <= nt * DIV + 2), 1'b1)
		end
		wait_res();
		`CHK(result_available_n, 1'b0)
		@(posedge ref_clk);
		start_pin <= 1'b0;
		@(posedge ref_clk);
	endtask

	initial begin
		seed_v = $urandom(32'hBC89);
		rst = 1'b1;
		{start_pin, cmd_start, cmd_stop, input_step, rd_seen} = '0;
		bus = '0;
		cal = '0;
		sample = '0;
		{mismatches, num_checks, cycles} = '0;
		repeat (3) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		for (int j = 0; j < 6; j++) rd(4'(j), (j == 5) ? 8'h40 : 8'h00);
		rd(4'hB, 8'h00);
		for (int j = 0; j < 6; j++) begin
			exp_b = 8'($urandom);
			wr(4'(j), exp_b);
			rd(4'(j), exp_b);
		end
		// calibration loads land whole in the byte registers
		for (int k = 0; k < 2; k++) begin
			w = 24'($urandom);
			cal.word <= w;
			cal.load_offset <= (k == 0);
			cal.load_gain <= (k == 1);
			@(posedge ref_clk);
			cal <= '0;
			@(posedge ref_clk);
			for (int j = 0; j < 3; j++) rd(4'(3 * k + j), w[8*j +: 8]);
		end
		conv(8'h80, OFS_RESET, GAIN_UNITY, 24'($urandom), 1'b0);
		for (int c = 1; c < 8; c++) conv({5'h10, c[2:0]}, 24'($urandom), GAIN_UNITY, 24'($urandom), 1'b0);
		conv(8'h80, 24'($urandom), 24'h800000, 24'($urandom), 1'b1);
		conv(8'h80, 24'($urandom), 24'h200000, 24'($urandom), 1'b1);
		conv(8'h80, 24'($urandom), 24'h000000, 24'($urandom), 1'b1);
		conv(8'h88, 24'($urandom), 24'($urandom), 24'($urandom), 1'b0);
		conv(8'h80, 24'h800000, GAIN_UNITY, 24'h7FFFFF, 1'b0);
		conv(8'h80, 24'h000001, 24'h800000, 24'h800000, 1'b0);
		// continuous run: settled after two results, lost again on an input step
		setup(8'h00, OFS_RESET, GAIN_UNITY);
		w = 24'($urandom);
		sample <= w;
		for (int k = 0; k < 3; k++) resq.push_back(w + 24'(k));
		cmd_start <= 1'b1;
		@(posedge ref_clk);
		cmd_start <= 1'b0;
		wait_res();
		@(negedge ref_clk);
		`CHK(data_settled, 1'b0)
		wait_res();
		@(negedge ref_clk);
		`CHK(data_settled, 1'b1)
		@(posedge ref_clk);
		input_step <= 1'b1;
		cmd_stop <= 1'b1;
		@(posedge ref_clk);
		input_step <= 1'b0;
		cmd_stop <= 1'b0;
		@(negedge ref_clk);
		@(negedge ref_clk);
		`CHK(data_settled, 1'b0)
		wait_res();
		// host restarts once the changed input has settled, so the first result counts
		conv(8'h80, OFS_RESET, GAIN_UNITY, 24'($urandom), 1'b0);
		repeat (60) @(posedge ref_clk);
		`CHK(resq.size(), 0)
		stop_test();
	end
endmodule
